// ---- src/srs_pkg.sv ----
package srs_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] SRS_ADR_CMD = 8'h00;
	localparam logic [7:0] SRS_ADR_ACC = 8'h04;
	localparam logic [7:0] SRS_ADR_STATUS = 8'h08;
	localparam logic [7:0] SRS_ADR_WDOG = 8'h0C;
	localparam logic [7:0] SRS_ADR_FINDEX = 8'h10;
	localparam logic [7:0] SRS_ADR_FDATA = 8'h14;
	// command word fields
	localparam int SRS_CMD_OP_LSB = 0;
	localparam int SRS_CMD_DEST_BIT = 2;
	localparam int SRS_CMD_FADDR_LSB = 8;
	localparam int SRS_CMD_LIT_LSB = 16;
	localparam int SRS_FADDR_W = 7;
	localparam int SRS_FILE_DEPTH = 128;
	// status bit positions
	localparam int SRS_ST_ARITH = 0;
	localparam int SRS_ST_NIBBLE = 1;
	localparam int SRS_ST_ZERO = 2;
	localparam int SRS_ST_PD = 3;
	localparam int SRS_ST_TO = 4;
	localparam int SRS_ST_SLEEP = 5;
	localparam int SRS_WDOG_PRE_LSB = 8;
	// reset values
	localparam logic [7:0] SRS_BYTE_ZERO = 8'h00;
	localparam logic [7:0] SRS_BYTE_ONE = 8'h01;
	localparam logic [31:0] SRS_WORD_ZERO = 32'h0000_0000;
	localparam logic SRS_PD_RESET = 1'b1;
	localparam logic SRS_TO_RESET = 1'b1;
	localparam logic SRS_DEST_ACC = 1'b0;
	localparam logic SRS_DEST_FILE = 1'b1;

	typedef enum logic [1:0]
	{
		SRS_OP_NONE = 2'b00,
		SRS_OP_SLEEP = 2'b01,
		SRS_OP_ROTATE = 2'b10,
		SRS_OP_SUB = 2'b11
	} srs_op_t;
endpackage

// ---- src/srs_rotate.sv ----
`timescale 1ns/100ps
module srs_rotate
(
	// operand
	input wire logic [7:0] value,
	input wire logic carry_in,
	// result
	output logic [7:0] result,
	output logic carry_out
);
	import srs_pkg::*;

	// checked in the same process so a half-updated operand cannot trip it
	always_comb
	begin
		result = {carry_in, value[7:1]};
		carry_out = value[0];
		rot_link_a : assert ({result, carry_out} == {carry_in, value})
		else $error("rotate result does not match operand");
	end
endmodule

// ---- src/srs_subtract.sv ----
`timescale 1ns/100ps
module srs_subtract
(
	// operands
	input wire logic [7:0] literal,
	input wire logic [7:0] acc,
	// result
	output logic [7:0] diff,
	output logic arith,
	output logic nibble,
	output logic zero
);
	import srs_pkg::*;

	logic [8:0] wide;
	logic [4:0] low;

	always_comb
	begin
		// borrow out of bit 8 means acc exceeded the literal
		wide = {1'b0, literal} - {1'b0, acc};
		low = {1'b0, literal[3:0]} - {1'b0, acc[3:0]};
		diff = wide[7:0];
		arith = ~wide[8];
		nibble = ~low[4];
		zero = (wide[7:0] == SRS_BYTE_ZERO);
		sub_flags_a : assert (arith == (acc <= literal) && nibble == (acc[3:0] <= literal[3:0]))
		else $error("subtract flags wrong");
	end
endmodule

// ---- src/srs_exec.sv ----
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
module srs_exec
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// low power
	input wire logic wake,
	output logic osc_stop
);
	import srs_pkg::*;

	// architectural state
	logic [7:0] accumulator;
	logic arith_flag;
	logic nibble_borrow_flag;
	logic zero_flag;
	logic powerdown_flag;
	logic timeout_flag;
	logic [7:0] watchdog_counter;
	logic [7:0] watchdog_prescaler;
	logic [31:0] last_cmd;
	logic [SRS_FADDR_W-1:0] file_index;
	logic [7:0] file_mem [0:SRS_FILE_DEPTH-1];

	// wake pin synchroniser
	logic wake_meta;
	logic wake_sync;

	// bus decode
	logic bus_req;
	logic bus_wr;
	logic bus_rd;
	logic wr_cmd;

	// decoded command
	srs_op_t cmd_op;
	logic cmd_dest;
	logic [SRS_FADDR_W-1:0] cmd_faddr;
	logic [7:0] cmd_lit;
	logic exec_sleep;
	logic exec_rotate;
	logic exec_sub;

	// datapath results
	logic [7:0] src_byte;
	logic [7:0] rot_result;
	logic rot_carry;
	logic [7:0] sub_diff;
	logic sub_arith;
	logic sub_nibble;
	logic sub_zero;

	logic [7:0] next_accumulator;
	logic [31:0] next_rdata;
	logic [31:0] status_word;

	// new request only while ack is low, so one access per handshake
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = bus_req && wb_we_i;
	assign bus_rd = bus_req && !wb_we_i;
	assign wr_cmd = bus_wr && wb_adr_i == SRS_ADR_CMD && wb_sel_i[0];

	assign cmd_op = srs_op_t'(wb_dat_i[SRS_CMD_OP_LSB +: 2]);
	assign cmd_dest = wb_dat_i[SRS_CMD_DEST_BIT];
	assign cmd_faddr = wb_dat_i[SRS_CMD_FADDR_LSB +: SRS_FADDR_W];
	assign cmd_lit = wb_dat_i[SRS_CMD_LIT_LSB +: 8];

	// a halted core executes nothing until woken
	assign exec_sleep = wr_cmd && !osc_stop && cmd_op == SRS_OP_SLEEP;
	assign exec_rotate = wr_cmd && !osc_stop && cmd_op == SRS_OP_ROTATE;
	assign exec_sub = wr_cmd && !osc_stop && cmd_op == SRS_OP_SUB;

	assign src_byte = file_mem[cmd_faddr];

	srs_rotate u_rotate
	(
		.value(src_byte),
		.carry_in(arith_flag),
		.result(rot_result),
		.carry_out(rot_carry)
	);

	srs_subtract u_subtract
	(
		.literal(cmd_lit),
		.acc(accumulator),
		.diff(sub_diff),
		.arith(sub_arith),
		.nibble(sub_nibble),
		.zero(sub_zero)
	);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wake_meta <= 1'b0;
			wake_sync <= 1'b0;
		end
		else
		begin
			wake_meta <= wake;
			wake_sync <= wake_meta;
		end
	end

	always_comb
	begin
		next_accumulator = accumulator;
		if (exec_rotate && cmd_dest == SRS_DEST_ACC)
			next_accumulator = rot_result;
		else if (exec_sub)
			next_accumulator = sub_diff;
		else if (bus_wr && wb_adr_i == SRS_ADR_ACC && wb_sel_i[0])
			next_accumulator = wb_dat_i[7:0];
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			accumulator <= SRS_BYTE_ZERO;
		else
			accumulator <= next_accumulator;
	end

	// arithmetic flags; execution wins over a software write
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			arith_flag <= 1'b0;
			nibble_borrow_flag <= 1'b0;
			zero_flag <= 1'b0;
		end
		else if (exec_rotate)
			arith_flag <= rot_carry;
		else if (exec_sub)
		begin
			arith_flag <= sub_arith;
			nibble_borrow_flag <= sub_nibble;
			zero_flag <= sub_zero;
		end
		else if (bus_wr && wb_adr_i == SRS_ADR_STATUS && wb_sel_i[0])
		begin
			arith_flag <= wb_dat_i[SRS_ST_ARITH];
			nibble_borrow_flag <= wb_dat_i[SRS_ST_NIBBLE];
			zero_flag <= wb_dat_i[SRS_ST_ZERO];
		end
	end

	// power flags read as one after reset, as on power-up
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			powerdown_flag <= SRS_PD_RESET;
			timeout_flag <= SRS_TO_RESET;
		end
		else if (exec_sleep)
		begin
			powerdown_flag <= 1'b0;
			timeout_flag <= 1'b1;
		end
		else if (bus_wr && wb_adr_i == SRS_ADR_STATUS && wb_sel_i[0])
		begin
			powerdown_flag <= wb_dat_i[SRS_ST_PD];
			timeout_flag <= wb_dat_i[SRS_ST_TO];
		end
	end

	// halt until the synchronised wake pin is seen high; the level clears it, and sleep wins in the same cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			osc_stop <= 1'b0;
		else if (exec_sleep)
			osc_stop <= 1'b1;
		else if (wake_sync)
			osc_stop <= 1'b0;
	end

	// watchdog frozen while the oscillator is stopped
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			watchdog_counter <= SRS_BYTE_ZERO;
			watchdog_prescaler <= SRS_BYTE_ZERO;
		end
		else if (exec_sleep)
		begin
			watchdog_counter <= SRS_BYTE_ZERO;
			watchdog_prescaler <= SRS_BYTE_ZERO;
		end
		else if (!osc_stop)
		begin
			watchdog_prescaler <= watchdog_prescaler + SRS_BYTE_ONE;
			if (&watchdog_prescaler)
				watchdog_counter <= watchdog_counter + SRS_BYTE_ONE;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			last_cmd <= SRS_WORD_ZERO;
			file_index <= '0;
		end
		else
		begin
			if (wr_cmd)
				last_cmd <= wb_dat_i;
			if (bus_wr && wb_adr_i == SRS_ADR_FINDEX && wb_sel_i[0])
				file_index <= wb_dat_i[SRS_FADDR_W-1:0];
		end
	end

	// one flip-flop byte per file entry
	genvar gi;
	generate
		for (gi = 0; gi < SRS_FILE_DEPTH; gi++)
		begin : g_file
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
					file_mem[gi] <= SRS_BYTE_ZERO;
				else if (exec_rotate && cmd_dest == SRS_DEST_FILE && cmd_faddr == gi)
					file_mem[gi] <= rot_result;
				else if (bus_wr && wb_adr_i == SRS_ADR_FDATA && wb_sel_i[0] && file_index == gi)
					file_mem[gi] <= wb_dat_i[7:0];
			end
		end
	endgenerate

	always_comb
	begin
		status_word = SRS_WORD_ZERO;
		status_word[SRS_ST_ARITH] = arith_flag;
		status_word[SRS_ST_NIBBLE] = nibble_borrow_flag;
		status_word[SRS_ST_ZERO] = zero_flag;
		status_word[SRS_ST_PD] = powerdown_flag;
		status_word[SRS_ST_TO] = timeout_flag;
		status_word[SRS_ST_SLEEP] = osc_stop;
	end

	// unmapped addresses read zero and still acknowledge
	always_comb
	begin
		next_rdata = SRS_WORD_ZERO;
		case (wb_adr_i)
			SRS_ADR_CMD: next_rdata = last_cmd;
			SRS_ADR_ACC: next_rdata[7:0] = accumulator;
			SRS_ADR_STATUS: next_rdata = status_word;
			SRS_ADR_WDOG:
			begin
				next_rdata[7:0] = watchdog_counter;
				next_rdata[SRS_WDOG_PRE_LSB +: 8] = watchdog_prescaler;
			end
			SRS_ADR_FINDEX: next_rdata[SRS_FADDR_W-1:0] = file_index;
			SRS_ADR_FDATA: next_rdata[7:0] = file_mem[file_index];
			default: next_rdata = SRS_WORD_ZERO;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= SRS_WORD_ZERO;
		end
		else
		begin
			wb_ack_o <= bus_req;
			if (bus_rd)
				wb_dat_o <= next_rdata;
		end
	end

	sleep_pd_a : assert property (@(posedge clk) disable iff (!reset_n)
		exec_sleep |=> !powerdown_flag)
	else $error("powerdown flag not cleared by sleep");

	sleep_to_a : assert property (@(posedge clk) disable iff (!reset_n)
		exec_sleep |=> timeout_flag)
	else $error("timeout flag not set by sleep");

	sleep_wdog_a : assert property (@(posedge clk) disable iff (!reset_n)
		exec_sleep |=> watchdog_counter == SRS_BYTE_ZERO && watchdog_prescaler == SRS_BYTE_ZERO)
	else $error("watchdog not cleared by sleep");

	sleep_halt_a : assert property (@(posedge clk) disable iff (!reset_n)
		exec_sleep |=> osc_stop ##1 ($stable(watchdog_prescaler) && (osc_stop || $past(wake_sync))))
	else $error("core not halted after sleep");

	// the bus stays alive while halted, so software may still load the accumulator
	halt_frozen_a : assert property (@(posedge clk) disable iff (!reset_n)
		osc_stop && !exec_sleep |=> $stable(watchdog_counter) && $stable(watchdog_prescaler)
			&& ($stable(accumulator) || $past(bus_wr && wb_adr_i == SRS_ADR_ACC)))
	else $error("state moved while halted");

	rot_carry_a : assert property (@(posedge clk) disable iff (!reset_n)
		exec_rotate |=> arith_flag == $past(src_byte[0]) && $stable(zero_flag)
			&& $stable(nibble_borrow_flag) && $stable(powerdown_flag))
	else $error("rotate carry or flags wrong");

	rot_acc_a : assert property (@(posedge clk) disable iff (!reset_n)
		exec_rotate && cmd_dest == SRS_DEST_ACC
			|=> accumulator == {$past(arith_flag), $past(src_byte[7:1])}
			&& file_mem[$past(cmd_faddr)] == $past(src_byte))
	else $error("rotate to accumulator wrong");

	rot_file_a : assert property (@(posedge clk) disable iff (!reset_n)
		exec_rotate && cmd_dest == SRS_DEST_FILE
			|=> file_mem[$past(cmd_faddr)] == {$past(arith_flag), $past(src_byte[7:1])}
			&& $stable(accumulator))
	else $error("rotate to file register wrong");

	sub_diff_a : assert property (@(posedge clk) disable iff (!reset_n)
		exec_sub |=> accumulator == 8'($past(cmd_lit) - $past(accumulator)))
	else $error("subtract difference wrong");

	sub_carry_a : assert property (@(posedge clk) disable iff (!reset_n)
		exec_sub |=> arith_flag == ($past(accumulator) <= $past(cmd_lit))
			&& nibble_borrow_flag == ($past(accumulator[3:0]) <= $past(cmd_lit[3:0])))
	else $error("subtract borrow flags wrong");

	sub_zero_a : assert property (@(posedge clk) disable iff (!reset_n)
		exec_sub |=> zero_flag == (accumulator == SRS_BYTE_ZERO))
	else $error("zero flag wrong after subtract");

	sub_power_a : assert property (@(posedge clk) disable iff (!reset_n)
		exec_sub |=> $stable(powerdown_flag) && $stable(timeout_flag) && !osc_stop)
	else $error("subtract touched power state");

	bus_ack_a : assert property (@(posedge clk) disable iff (!reset_n)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
	else $error("wishbone ack not one cycle");
endmodule

// ---- tb/srs_wake_src.sv ----
`timescale 1ns/100ps
module srs_wake_src
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// request from the bench
	input wire logic req,
	// wake pin
	output logic wake
);
	logic [1:0] left;

	// three cycles high so two sync flops always catch it
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			left <= 2'h0;
		else if (req)
			left <= 2'h3;
		else if (left != 2'h0)
			left <= left - 2'h1;
	end

	assign wake = (left != 2'h0);
endmodule

// ---- tb/test_srs_exec.sv ----
`timescale 1ns/100ps
module test_srs_exec;
	import srs_pkg::*;
	logic clk, reset_n, cyc, stb, we, req, ack, wake, osc_stop;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, dat_o, q;
	int n_fail, compares, cycles;

	srs_exec dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.wake(wake), .osc_stop(osc_stop));
	srs_wake_src far (.clk(clk), .reset_n(reset_n), .req(req), .wake(wake));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic close_out();
		$display("fails %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_fail++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one classic cycle; waits for ack with no assumed latency
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= a;
		dat <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	function automatic logic [31:0] cmd(logic [1:0] op, logic d, logic [6:0] f, logic [7:0] k);
		cmd = {8'h00, k, 1'b0, f, 5'h00, d, op};
	endfunction

	task automatic sub_case(input logic [7:0] k, input logic [7:0] a);
		logic [7:0] diff;
		diff = k - a;
		wb(1'b1, SRS_ADR_ACC, {24'h0, a});
		wb(1'b1, SRS_ADR_CMD, cmd(SRS_OP_SUB, 1'b0, 7'h00, k));
		wb(1'b0, SRS_ADR_ACC, 32'h0);
		chk(q & 32'hFF, {24'h0, diff});
		wb(1'b0, SRS_ADR_STATUS, 32'h0);
		chk(q & 32'h7, {29'h0, diff == 8'h00, a[3:0] <= k[3:0], a <= k});
	endtask

	initial
	begin
		{cyc, stb, we, req} = 4'h0;
		adr = 8'h00;
		sel = 4'hF;
		dat = 32'h0;
		n_fail = 0;
		compares = 0;
		cycles = 0;
		reset_n = 1'b0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		wb(1'b0, SRS_ADR_STATUS, 32'h0);
		chk(q & 32'h3F, 32'h18);
		// rotate into acc, source kept, carry 0 in
		wb(1'b1, SRS_ADR_FINDEX, 32'h05);
		wb(1'b1, SRS_ADR_FDATA, 32'hE6);
		wb(1'b1, SRS_ADR_STATUS, 32'h1E);
		wb(1'b1, SRS_ADR_CMD, cmd(SRS_OP_ROTATE, SRS_DEST_ACC, 7'h05, 8'h00));
		wb(1'b0, SRS_ADR_ACC, 32'h0);
		chk(q & 32'hFF, 32'h73);
		wb(1'b0, SRS_ADR_FDATA, 32'h0);
		chk(q & 32'hFF, 32'hE6);
		wb(1'b0, SRS_ADR_STATUS, 32'h0);
		chk(q & 32'h1F, 32'h1E);
		// top file address, write back, carry 1 in and out
		wb(1'b1, SRS_ADR_FINDEX, 32'h7F);
		wb(1'b1, SRS_ADR_FDATA, 32'h01);
		wb(1'b1, SRS_ADR_STATUS, 32'h1F);
		wb(1'b1, SRS_ADR_CMD, cmd(SRS_OP_ROTATE, SRS_DEST_FILE, 7'h7F, 8'h00));
		wb(1'b0, SRS_ADR_FDATA, 32'h0);
		chk(q & 32'hFF, 32'h80);
		wb(1'b0, SRS_ADR_STATUS, 32'h0);
		chk(q & 32'h1F, 32'h1F);
		// subtract: equal, borrow, nibble borrow only, extremes
		sub_case(8'h10, 8'h10);
		sub_case(8'h05, 8'h06);
		sub_case(8'h20, 8'h01);
		sub_case(8'hFF, 8'h00);
		sub_case(8'h00, 8'hFF);
		// sleep from a known pd=1 to=0 state with the watchdog running
		wb(1'b1, SRS_ADR_STATUS, 32'h08);
		repeat (300) @(posedge clk);
		wb(1'b0, SRS_ADR_WDOG, 32'h0);
		chk({31'h0, (q & 32'hFF) != 32'h0}, 32'h1);
		wb(1'b1, SRS_ADR_CMD, cmd(SRS_OP_SLEEP, 1'b0, 7'h00, 8'h00));
		wb(1'b0, SRS_ADR_STATUS, 32'h0);
		chk(q & 32'h38, 32'h30);
		wb(1'b0, SRS_ADR_WDOG, 32'h0);
		chk(q & 32'hFFFF, 32'h0);
		chk({31'h0, osc_stop}, 32'h1);
		// commands are not run while halted
		wb(1'b1, SRS_ADR_ACC, 32'h42);
		wb(1'b1, SRS_ADR_CMD, cmd(SRS_OP_SUB, 1'b0, 7'h00, 8'h00));
		wb(1'b0, SRS_ADR_ACC, 32'h0);
		chk(q & 32'hFF, 32'h42);
		@(posedge clk);
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		repeat (10) @(posedge clk);
		chk({31'h0, osc_stop}, 32'h0);
		repeat (300) @(posedge clk);
		wb(1'b0, SRS_ADR_WDOG, 32'h0);
		chk({31'h0, (q & 32'hFF) != 32'h0}, 32'h1);
		wb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		close_out();
	end
endmodule
